/* hw/aic_defs.svh */
// Register offsets, field positions, write masks and reset values of the ADC input configuration block.
`ifndef AIC_DEFS_SVH
`define AIC_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets (word index on the register port)
// ----------------------------------------------------------------------------
`define AIC_OFS_DMA_CFG 5'h00
`define AIC_OFS_AUX_SEL 5'h01
`define AIC_OFS_MAIN_SEL 5'h02
`define AIC_OFS_SCAN_HI 5'h03
`define AIC_OFS_CTRL 5'h04
`define AIC_BUF_SEL_BIT 4

// ----------------------------------------------------------------------------
// Implemented bits of each register
// ----------------------------------------------------------------------------
`define AIC_MASK_DMA_CFG 16'h0107
`define AIC_MASK_AUX_SEL 16'h1f1f
`define AIC_MASK_MAIN_SEL 16'hbfbf
`define AIC_MASK_SCAN_HI 16'hff0f
`define AIC_MASK_CTRL 16'h077d
`define AIC_RST_VAL 16'h0000

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define AIC_DMA_EN_BIT 8
`define AIC_WPI_LSB 0
`define AIC_AUX_SA_HI_LSB 3
`define AIC_AUX_SA_LO_BIT 0
`define AIC_AUX_NA_LSB 1
`define AIC_AUX_SB_HI_LSB 11
`define AIC_AUX_SB_LO_BIT 8
`define AIC_AUX_NB_LSB 9
`define AIC_MAIN_SA_LSB 0
`define AIC_MAIN_NA_BIT 7
`define AIC_MAIN_SB_LSB 8
`define AIC_MAIN_NB_BIT 15
`define AIC_CTRL_ALTERNATE_MUX_ENABLE_BIT 0
`define AIC_CTRL_RATE_LSB 2
`define AIC_CTRL_CNT_LSB 8
`define AIC_CTRL_SCAN_BIT 10

// ----------------------------------------------------------------------------
// Fixed input numbers
// ----------------------------------------------------------------------------
`define AIC_SCAN_BASE_INPUT 6'd16
`define AIC_MAIN_NEG_INPUT 6'd1

`endif

/* hw/aic_pkg.sv */
// Types shared by the ADC input configuration block.
`default_nettype none
package aic_pkg;

	typedef enum logic {
		AIC_PH_A = 1'b0,
		AIC_PH_B = 1'b1
	} aic_phase_e;

	typedef struct packed {
		logic [5:0] pos;
		logic pos_amp;
		logic pos_lowref;
		logic [5:0] neg;
		logic neg_lowref;
	} aic_chan_sel_s;

	typedef struct packed {
		logic [15:0] dma_cfg;
		logic [15:0] aux_sel;
		logic [15:0] main_sel;
		logic [15:0] scan_hi;
		logic [15:0] ctrl;
		logic [15:0][15:0] rbuf;
		logic [3:0] wr_ptr;
		logic [3:0] scan_ptr;
		logic [4:0] smp_cnt;
		aic_phase_e phase;
		aic_chan_sel_s [3:0] sel;
		logic [3:0] ch_active;
		logic mux_b;
		logic dma_req;
		logic dma_inc;
		logic [7:0] dma_words;
		logic [15:0] rdata;
	} aic_state_s;

endpackage
`default_nettype wire

/* hw/aic_top.sv */
// ADC input multiplexer, scan, result buffer and DMA configuration logic.
//
// Contract
// - DMA mode on: every result goes into the first result register.
// - DMA mode off: results fill sixteen buffer registers, no DMA activity.
// - Words-per-input field allocates two to the power of its code words.
// - Unimplemented bits read zero and ignore writes.
// - Sample A aux positive code: high bits at 4..3, low bit at 0.
// - Aux positive code 000 gives inputs 0,1,2; code 001 gives 3,4,5.
// - Code 010 gives 3,0,6; 011 gives 3,0,25; 1xx gives 0,25,6.
// - Sample B aux positive code: high bits at 12..11, low bit at 8.
// - Aux negative code 11 gives 9,10,11; 10 gives 6,7,8; 0x low reference.
// - Sample B aux negative select sits at bits 10..9.
// - Sample A aux negative select sits at bits 2..1.
// - Main negative B at bit 15: input 1 when set, else low reference.
// - Main negative A at bit 7: input 1 when set, else low reference.
// - Main positive B is six bits at 13..8 selecting input N.
// - Main positive A is six bits at 5..0, same encoding.
// - Codes 61, 62, 63 select band gap, temperature diode, unconnected.
// - Enabled amplifier routes its output instead of the shared pin.
// - Scan bits 15..8 map inputs 31..24, 3..0 map 19..16, 7..4 absent.
// - Scan bits stay writable; absent inputs convert the low reference.
// - Scan enable steps main positive through scanned inputs on sample A.
// - Alternate enable switches A and B each sample; otherwise always A.
// - In DMA mode address advances every increment rate plus one results.
// - Channel count: 00 channel 0, 01 channels 0-1, 1x channels 0-3.
`timescale 1ns/10ps
`default_nettype none
`include "aic_defs.svh"

module aic_top
	import aic_pkg::*;
#(
	parameter logic [63:0] PRESENT_MASK = 64'h6000_0000_ffff_ffff
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [4:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic sample_start_i,
	input wire logic result_valid_i,
	input wire logic [15:0] result_i,
	input wire logic [4:0] amp_enable_i,
	output aic_chan_sel_s [3:0] chan_sel_o,
	output logic [3:0] ch_active_o,
	output logic mux_b_o,
	output logic dma_req_o,
	output logic dma_addr_inc_o,
	output logic [7:0] dma_words_o,
	output logic [15:0] first_result_o
);

	// ------------------------------------------------------------------------
	// Input routing tables
	// ------------------------------------------------------------------------

	// Positive inputs of channels 3, 2, 1 packed as {ch3, ch2, ch1}.
	function automatic logic [17:0] aux_pos(input logic [2:0] code);
		logic [17:0] r;
		r = '0;
		case (code)
			3'b000: r = {6'd2, 6'd1, 6'd0};
			3'b001: r = {6'd5, 6'd4, 6'd3};
			3'b010: r = {6'd6, 6'd0, 6'd3};
			3'b011: r = {6'd25, 6'd0, 6'd3};
			default: r = {6'd6, 6'd25, 6'd0};
		endcase
		return r;
	endfunction

	// Negative inputs of channels 3, 2, 1 with a low reference flag on top.
	function automatic logic [18:0] aux_neg(input logic [1:0] code);
		logic [18:0] r;
		r = '0;
		case (code)
			2'b11: r = {1'b0, 6'd11, 6'd10, 6'd9};
			2'b10: r = {1'b0, 6'd8, 6'd7, 6'd6};
			default: r = {1'b1, 18'h00000};
		endcase
		return r;
	endfunction

	// Inputs shared with an amplifier take the amplifier output when it is on.
	function automatic logic amp_on(input logic [5:0] num, input logic [4:0] en);
		logic r;
		r = 1'b0;
		case (num)
			6'd3: r = en[0];
			6'd0: r = en[1];
			6'd6: r = en[2];
			6'd25: r = en[4];
			default: r = 1'b0;
		endcase
		return r;
	endfunction

	// Fill one channel selection; absent inputs fall back to the low reference.
	function automatic aic_chan_sel_s mk_sel(input logic [5:0] pos, input logic [5:0] neg,
			input logic neg_low, input logic [4:0] en);
		aic_chan_sel_s r;
		r.pos = pos;
		r.pos_amp = amp_on(pos, en);
		r.pos_lowref = ~PRESENT_MASK[pos];
		r.neg = neg_low ? 6'd0 : neg;
		r.neg_lowref = neg_low;
		return r;
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	aic_state_s s_reg;
	aic_state_s s_next;

	logic dma_en;
	logic alternate_mux_enable;
	logic scan_en;
	logic [4:0] rate;
	logic [1:0] cnt_sel;
	logic use_b;

	assign dma_en = s_reg.dma_cfg[`AIC_DMA_EN_BIT];
	assign alternate_mux_enable = s_reg.ctrl[`AIC_CTRL_ALTERNATE_MUX_ENABLE_BIT];
	assign scan_en = s_reg.ctrl[`AIC_CTRL_SCAN_BIT];
	assign rate = s_reg.ctrl[`AIC_CTRL_RATE_LSB +: 5];
	assign cnt_sel = s_reg.ctrl[`AIC_CTRL_CNT_LSB +: 2];
	assign use_b = alternate_mux_enable && (s_reg.phase == AIC_PH_B);

	always_comb begin
		logic [2:0] pcode;
		logic [1:0] ncode;
		logic [17:0] apos;
		logic [18:0] aneg;
		logic [5:0] pos0;
		logic neg0;
		logic found;
		logic [3:0] idx;
		logic [3:0] cand;
		pcode = '0;
		ncode = '0;
		apos = '0;
		aneg = '0;
		pos0 = '0;
		neg0 = 1'b0;
		found = 1'b0;
		idx = '0;
		cand = '0;
		s_next = s_reg;
		s_next.dma_req = 1'b0;
		s_next.dma_inc = 1'b0;
		s_next.rdata = '0;

		// --------------------------------------------------------------------
		// Register writes; unimplemented bits are masked off on the way in.
		// --------------------------------------------------------------------
		if (wr_i) begin
			case (addr_i)
				`AIC_OFS_DMA_CFG: s_next.dma_cfg = wdata_i & `AIC_MASK_DMA_CFG;
				`AIC_OFS_AUX_SEL: s_next.aux_sel = wdata_i & `AIC_MASK_AUX_SEL;
				`AIC_OFS_MAIN_SEL: s_next.main_sel = wdata_i & `AIC_MASK_MAIN_SEL;
				`AIC_OFS_SCAN_HI: begin
					s_next.scan_hi = wdata_i & `AIC_MASK_SCAN_HI;
					s_next.scan_ptr = '0;
				end
				`AIC_OFS_CTRL: begin
					s_next.ctrl = wdata_i & `AIC_MASK_CTRL;
					s_next.scan_ptr = '0;
					s_next.phase = AIC_PH_A;
				end
				default: begin
				end
			endcase
		end

		// --------------------------------------------------------------------
		// Register reads; data appear in the following cycle only.
		// --------------------------------------------------------------------
		if (rd_i) begin
			if (addr_i[`AIC_BUF_SEL_BIT]) begin
				s_next.rdata = s_reg.rbuf[addr_i[3:0]];
			end else begin
				case (addr_i)
					`AIC_OFS_DMA_CFG: s_next.rdata = s_reg.dma_cfg;
					`AIC_OFS_AUX_SEL: s_next.rdata = s_reg.aux_sel;
					`AIC_OFS_MAIN_SEL: s_next.rdata = s_reg.main_sel;
					`AIC_OFS_SCAN_HI: s_next.rdata = s_reg.scan_hi;
					`AIC_OFS_CTRL: s_next.rdata = s_reg.ctrl;
					default: s_next.rdata = '0;
				endcase
			end
		end

		// --------------------------------------------------------------------
		// Result storage and DMA pacing.
		// --------------------------------------------------------------------
		if (result_valid_i) begin
			if (dma_en) begin
				s_next.rbuf[0] = result_i;
				s_next.dma_req = 1'b1;
				if (s_reg.smp_cnt == rate) begin
					s_next.dma_inc = 1'b1;
					s_next.smp_cnt = '0;
				end else begin
					s_next.smp_cnt = s_reg.smp_cnt + 5'd1;
				end
			end else begin
				s_next.rbuf[s_reg.wr_ptr] = result_i;
				s_next.wr_ptr = s_reg.wr_ptr + 4'd1;
				s_next.smp_cnt = '0;
			end
		end

		// Buffer words per input follow the register immediately.
		s_next.dma_words = 8'h01 << s_next.dma_cfg[`AIC_WPI_LSB +: 3];

		// --------------------------------------------------------------------
		// Input selection, latched at the start of every sample.
		// --------------------------------------------------------------------
		for (int i = 0; i < 16; i++) begin
			cand = s_reg.scan_ptr + 4'(i);
			if (!found && s_reg.scan_hi[cand]) begin
				found = 1'b1;
				idx = cand;
			end
		end
		if (use_b) begin
			pcode = {s_reg.aux_sel[`AIC_AUX_SB_HI_LSB +: 2], s_reg.aux_sel[`AIC_AUX_SB_LO_BIT]};
			ncode = s_reg.aux_sel[`AIC_AUX_NB_LSB +: 2];
			pos0 = s_reg.main_sel[`AIC_MAIN_SB_LSB +: 6];
			neg0 = s_reg.main_sel[`AIC_MAIN_NB_BIT];
		end else begin
			pcode = {s_reg.aux_sel[`AIC_AUX_SA_HI_LSB +: 2], s_reg.aux_sel[`AIC_AUX_SA_LO_BIT]};
			ncode = s_reg.aux_sel[`AIC_AUX_NA_LSB +: 2];
			pos0 = s_reg.main_sel[`AIC_MAIN_SA_LSB +: 6];
			neg0 = s_reg.main_sel[`AIC_MAIN_NA_BIT];
			if (scan_en && found) begin
				pos0 = `AIC_SCAN_BASE_INPUT + {2'b00, idx};
			end
		end
		apos = aux_pos(pcode);
		aneg = aux_neg(ncode);
		if (sample_start_i) begin
			s_next.sel[0] = mk_sel(pos0, `AIC_MAIN_NEG_INPUT, ~neg0, amp_enable_i);
			s_next.sel[1] = mk_sel(apos[5:0], aneg[5:0], aneg[18], amp_enable_i);
			s_next.sel[2] = mk_sel(apos[11:6], aneg[11:6], aneg[18], amp_enable_i);
			s_next.sel[3] = mk_sel(apos[17:12], aneg[17:12], aneg[18], amp_enable_i);
			s_next.mux_b = use_b;
			if (!use_b && scan_en && found) begin
				s_next.scan_ptr = idx + 4'd1;
			end
			if (alternate_mux_enable) begin
				s_next.phase = (s_reg.phase == AIC_PH_A) ? AIC_PH_B : AIC_PH_A;
			end else begin
				s_next.phase = AIC_PH_A;
			end
			case (cnt_sel)
				2'b00: s_next.ch_active = 4'h1;
				2'b01: s_next.ch_active = 4'h3;
				default: s_next.ch_active = 4'hf;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			// Words per input restart at one, the size that code 000 selects.
			s_reg <= '0;
			s_reg.dma_words <= 8'h01;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign rdata_o = s_reg.rdata;
	assign chan_sel_o = s_reg.sel;
	assign ch_active_o = s_reg.ch_active;
	assign mux_b_o = s_reg.mux_b;
	assign dma_req_o = s_reg.dma_req;
	assign dma_addr_inc_o = s_reg.dma_inc;
	assign dma_words_o = s_reg.dma_words;
	assign first_result_o = s_reg.rbuf[0];

	// ------------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_start_a;
		sample_start_i && !use_b;
	endsequence

	sequence s_start_b;
		sample_start_i && use_b;
	endsequence

	AST_DMA_RESULT: assert property (result_valid_i && dma_en |=> dma_req_o && first_result_o == $past(result_i))
		else $error("DMA mode result not placed in first result register.");

	AST_BUFFER_FILL: assert property (result_valid_i && !dma_en |=>
			!dma_req_o && s_reg.rbuf[$past(s_reg.wr_ptr)] == $past(result_i))
		else $error("Buffered result missing or DMA request raised.");

	AST_WORDS: assert property (dma_words_o == (8'h01 << s_reg.dma_cfg[`AIC_WPI_LSB +: 3]))
		else $error("Words per input do not match the configured code.");

	AST_RSVD_ZERO: assert property (rd_i && addr_i == `AIC_OFS_DMA_CFG |=>
			(rdata_o & ~`AIC_MASK_DMA_CFG) == 16'h0000)
		else $error("Unimplemented bits read nonzero.");

	AST_AUX_CODE0: assert property (s_start_a ##0 (pcode_a() == 3'b000) |=>
			chan_sel_o[1].pos == 6'd0 && chan_sel_o[2].pos == 6'd1 && chan_sel_o[3].pos == 6'd2)
		else $error("Aux code 000 routed wrong inputs.");

	AST_ALT_SWAP: assert property (s_start_a ##1 s_start_b |=> mux_b_o)
		else $error("Alternate sample did not use mux B.");

	AST_ALT_NEXT: assert property (sample_start_i && alternate_mux_enable && s_reg.phase == AIC_PH_A |=> s_reg.phase == AIC_PH_B)
		else $error("Alternate mode did not advance to mux B.");

	AST_RATE: assert property (result_valid_i && dma_en && s_reg.smp_cnt == rate |=>
			dma_addr_inc_o && s_reg.smp_cnt == 5'd0)
		else $error("DMA address increment missed.");

	AST_MAIN_NEG_A: assert property (s_start_a ##0 s_reg.main_sel[`AIC_MAIN_NA_BIT] |=>
			chan_sel_o[0].neg == 6'd1 && !chan_sel_o[0].neg_lowref)
		else $error("Main negative A did not select input 1.");

	AST_SCAN_FIRST: assert property (s_start_a ##0 (scan_en && s_reg.scan_hi == 16'h0001) |=>
			chan_sel_o[0].pos == 6'd16)
		else $error("Scan did not select input 16.");

	AST_AMP_ROUTE: assert property (s_start_a ##0 (pcode_a() == 3'b100 && amp_enable_i[1]) |=>
			chan_sel_o[1].pos_amp)
		else $error("Amplifier output not routed.");

	// Checks of the remaining selection fields and of DMA silence.
	AST_CH_COUNT: assert property (sample_start_i && cnt_sel == 2'b01 |=> ch_active_o == 4'h3)
		else $error("Channel count code 01 did not select two channels.");

	AST_MAIN_NEG_B: assert property (s_start_b ##0 s_reg.main_sel[`AIC_MAIN_NB_BIT] |=>
			chan_sel_o[0].neg == 6'd1 && !chan_sel_o[0].neg_lowref)
		else $error("Main negative B did not select input 1.");

	AST_AUX_NEG_LOW: assert property (s_start_a ##0 !s_reg.aux_sel[`AIC_AUX_NA_LSB + 1] |=>
			chan_sel_o[1].neg_lowref && chan_sel_o[2].neg_lowref && chan_sel_o[3].neg_lowref)
		else $error("Aux negative code 0x did not select the low reference.");

	AST_AUX_NEG_HI: assert property (s_start_b ##0 s_reg.aux_sel[`AIC_AUX_NB_LSB +: 2] == 2'b11 |=>
			chan_sel_o[1].neg == 6'd9 && chan_sel_o[3].neg == 6'd11)
		else $error("Aux negative B code 11 routed wrong inputs.");

	AST_SCAN_OFF: assert property (s_start_a ##0 !scan_en |=>
			chan_sel_o[0].pos == $past(s_reg.main_sel[`AIC_MAIN_SA_LSB +: 6]))
		else $error("Main positive A not used while scanning is off.");

	AST_NO_SWAP: assert property (sample_start_i && !alternate_mux_enable |=> !mux_b_o)
		else $error("Mux B used while alternate mode is off.");

	AST_DMA_QUIET: assert property (!dma_en |=> !dma_req_o && !dma_addr_inc_o)
		else $error("DMA activity while DMA mode is off.");

	function automatic logic [2:0] pcode_a();
		return {s_reg.aux_sel[`AIC_AUX_SA_HI_LSB +: 2], s_reg.aux_sel[`AIC_AUX_SA_LO_BIT]};
	endfunction

endmodule
`default_nettype wire

/* testbench/aic_dma_partner.sv */
// Result source and transfer engine model on the far side of the converter block.
`timescale 1ns/10ps
`default_nettype none
module aic_dma_partner (
	input wire logic clk_i,
	input wire logic dma_req_i,
	input wire logic [15:0] first_result_i,
	output logic result_valid_o,
	output logic [15:0] result_o
);
	logic [15:0] got_q[$];

	initial begin
		result_valid_o = 1'b0;
		result_o = 16'h0000;
	end

	// Hands over one result as a single-cycle pulse; the data lines flip once released.
	task automatic send(input logic [15:0] d);
		@(posedge clk_i);
		result_valid_o <= 1'b1;
		result_o <= d;
		@(posedge clk_i);
		result_valid_o <= 1'b0;
		result_o <= ~d;
	endtask

	// The engine fetches the first result register once for every request.
	always @(posedge clk_i) begin
		if (dma_req_i === 1'b1) begin
			got_q.push_back(first_result_i);
		end
	end
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the ADC input configuration block.
`timescale 1ns/10ps
`default_nettype none
`include "aic_defs.svh"
module testbench import aic_pkg::*;;
	localparam logic [63:0] PM = 64'h6000_0000_fff7_ffff;
	localparam logic [15:0] SCM = 16'h810d;
	logic clk_i, rst_i, wr_i, rd_i, sample_start_i, result_valid_i, mux_b_o, dma_req_o, dma_addr_inc_o;
	logic [4:0] addr_i, amp_i;
	logic [15:0] wdata_i, rdata_o, first_result_o, res_d, aux, mn, d;
	logic [15:0] bm[16];
	aic_chan_sel_s [3:0] chan_sel_o, e;
	logic [3:0] ch_active_o;
	logic [7:0] dma_words_o;
	int error_cnt, tests_run, seed, sp;
	int ptab[5][3] = '{'{0, 1, 2}, '{3, 4, 5}, '{3, 0, 6}, '{3, 0, 25}, '{0, 25, 6}};
	logic [4:0] ofs[5] = '{`AIC_OFS_DMA_CFG, `AIC_OFS_AUX_SEL, `AIC_OFS_MAIN_SEL, `AIC_OFS_SCAN_HI, `AIC_OFS_CTRL};
	logic [15:0] msk[5] = '{`AIC_MASK_DMA_CFG, `AIC_MASK_AUX_SEL, `AIC_MASK_MAIN_SEL, `AIC_MASK_SCAN_HI, `AIC_MASK_CTRL};

	aic_top #(.PRESENT_MASK(PM)) u_aic_top (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sample_start_i(sample_start_i),
		.result_valid_i(result_valid_i), .result_i(res_d), .amp_enable_i(amp_i), .chan_sel_o(chan_sel_o),
		.ch_active_o(ch_active_o), .mux_b_o(mux_b_o), .dma_req_o(dma_req_o), .dma_addr_inc_o(dma_addr_inc_o),
		.dma_words_o(dma_words_o), .first_result_o(first_result_o));
	aic_dma_partner u_aic_dma_partner (.clk_i(clk_i), .dma_req_i(dma_req_o), .first_result_i(first_result_o),
		.result_valid_o(result_valid_i), .result_o(res_d));

	task automatic chk(input string n, input logic [63:0] exp, input logic [63:0] got);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, exp, got);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= v;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk("rdata", 64'(exp), 64'(rdata_o));
	endtask

	task automatic smp(input int n = 1);
		@(posedge clk_i);
		sample_start_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		sample_start_i <= 1'b0;
		@(negedge clk_i);
	endtask

	function automatic aic_chan_sel_s mk(input int p, input int n);
		aic_chan_sel_s s;
		s.pos = p[5:0];
		s.pos_amp = (p == 3 && amp_i[0]) || (p == 0 && amp_i[1]) || (p == 6 && amp_i[2]) || (p == 25 && amp_i[4]);
		s.pos_lowref = !PM[p];
		s.neg = (n < 0) ? 6'h00 : n[5:0];
		s.neg_lowref = (n < 0);
		return s;
	endfunction

	// Reference selection for one sample; a scan input of -1 means the main field is used.
	task automatic model(input logic b, input int scan);
		logic [2:0] c;
		logic [1:0] nc;
		c = b ? {aux[12:11], aux[8]} : {aux[4:3], aux[0]};
		nc = b ? aux[10:9] : aux[2:1];
		e[0] = mk((scan >= 0) ? scan : int'(b ? mn[13:8] : mn[5:0]), (b ? mn[15] : mn[7]) ? 1 : -1);
		for (int k = 1; k < 4; k++) begin
			e[k] = mk(ptab[c[2] ? 4 : c][k - 1], nc[1] ? (nc[0] ? 8 : 5) + k : -1);
		end
	endtask

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		wrap_up();
	end

	initial begin
		rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		sample_start_i = 1'b0;
		addr_i = 5'h00;
		wdata_i = 16'h0000;
		amp_i = 5'h00;
		seed = 23;
		error_cnt = 0;
		tests_run = 0;
		do_reset();
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i], 16'h0000);
			wr(ofs[i], 16'hffff);
			rd(ofs[i], msk[i]);
		end
		wr(5'h08, 16'hffff);
		rd(5'h08, 16'h0000);
		$display("test registers done");
		for (int i = 0; i < 4; i++) begin
			wr(`AIC_OFS_CTRL, 16'(i << 8));
			smp();
			chk("ch_active", (i == 0) ? 64'h1 : (i == 1) ? 64'h3 : 64'hf, 64'(ch_active_o));
		end
		for (int alt = 0; alt < 2; alt++) begin
			wr(`AIC_OFS_CTRL, 16'h0200 | 16'(alt));
			for (int i = 0; i < 24; i++) begin
				aux = 16'($random(seed));
				mn = 16'($random(seed));
				if (i < 6) begin
					mn[13:8] = 6'(61 + i / 2);
					mn[5:0] = 6'(61 + i / 2);
				end
				amp_i <= 5'($random(seed));
				wr(`AIC_OFS_AUX_SEL, aux);
				wr(`AIC_OFS_MAIN_SEL, mn);
				smp();
				model(alt[0] & i[0], -1);
				chk("chan_sel", 64'(e), 64'(chan_sel_o));
				chk("mux_b", 64'(alt[0] & i[0]), 64'(mux_b_o));
			end
		end
		smp(2);
		model(1'b1, -1);
		chk("chan_sel_b2b", 64'(e), 64'(chan_sel_o));
		chk("mux_b_b2b", 64'h1, 64'(mux_b_o));
		$display("test selection done");
		do_reset();
		wr(`AIC_OFS_SCAN_HI, 16'h81fd);
		rd(`AIC_OFS_SCAN_HI, SCM);
		wr(`AIC_OFS_CTRL, 16'h0600);
		aux = 16'h0000;
		mn = 16'h0000;
		amp_i <= 5'h00;
		sp = 15;
		for (int i = 0; i < 7; i++) begin
			do sp = (sp + 1) % 16; while (!SCM[sp]);
			smp();
			model(1'b0, 16 + sp);
			chk("scan_sel", 64'(e), 64'(chan_sel_o));
		end
		wr(`AIC_OFS_SCAN_HI, 16'h0001);
		smp();
		model(1'b0, 16);
		chk("scan_one", 64'(e), 64'(chan_sel_o));
		$display("test scan done");
		do_reset();
		for (int w = 0; w < 8; w++) begin
			wr(`AIC_OFS_DMA_CFG, 16'h0100 | 16'(w));
			@(posedge clk_i);
			@(negedge clk_i);
			chk("dma_words", 64'(1 << w), 64'(dma_words_o));
		end
		wr(`AIC_OFS_CTRL, 16'h0008);
		for (int k = 0; k < 9; k++) begin
			d = 16'($random(seed));
			u_aic_dma_partner.send(d);
			@(negedge clk_i);
			chk("dma_req", 64'h1, 64'(dma_req_o));
			chk("first_result", 64'(d), 64'(first_result_o));
			chk("dma_inc", 64'(k % 3 == 2), 64'(dma_addr_inc_o));
		end
		repeat (2) @(posedge clk_i);
		chk("dma_fetches", 64'd9, 64'(u_aic_dma_partner.got_q.size()));
		chk("dma_last", 64'(d), 64'(u_aic_dma_partner.got_q[$]));
		$display("test dma done");
		do_reset();
		for (int k = 0; k < 18; k++) begin
			d = 16'($random(seed));
			bm[k % 16] = d;
			u_aic_dma_partner.send(d);
			@(negedge clk_i);
			chk("dma_quiet", 64'h0, 64'({dma_req_o, dma_addr_inc_o}));
		end
		for (int i = 0; i < 16; i++) begin
			rd(5'h10 + 5'(i), bm[i]);
		end
		$display("test buffer done");
		wrap_up();
	end
endmodule
`default_nettype wire
